//--- src/bmrc_pkg.sv
// Shared constants for the cell-monitor read-back chain serial port
package bmrc_pkg;

	// ==========================================================
	// Frame geometry
	localparam int FRAME_BITS = 32;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] FRAME_BITS_CNT = 6'h20;
	localparam int ADDR_HI = 31; // Device address, sent LSB first
	localparam int ADDR_LO = 27;
	localparam int CHAN_HI = 26; // Channel code of a conversion frame
	localparam int CHAN_LO = 23;
	localparam int RES_HI = 22; // Conversion result
	localparam int RES_LO = 11;
	localparam int REGA_HI = 26; // Register address
	localparam int REGA_LO = 21;
	localparam int REGD_HI = 20; // Register data
	localparam int REGD_LO = 13;
	localparam int ACK_POS = 10; // Write acknowledge of read frames
	localparam int RCRC_HI = 9; // Read frame CRC
	localparam int RCRC_LO = 2;
	localparam int ALL_POS = 12; // Address-all bit of write frames
	localparam int WCRC_HI = 10; // Write frame CRC
	localparam int WCRC_LO = 3;
	localparam int WCOV_LO = 11; // Lowest bit covered by write CRC
	localparam int WCRC_LEN = 21; // Bits covered by write CRC
	localparam int RCRC_LEN = 22; // Bits covered by read CRC

	// ==========================================================
	// Field widths and fixed values
	localparam int DEV_W = 5;
	localparam int CHAN_W = 4;
	localparam int RES_W = 12;
	localparam int REGA_W = 6;
	localparam int REGD_W = 8;
	localparam logic [7:0] CRC_POLY = 8'h2F; // x^8+x^5+x^3+x^2+x+1
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [2:0] WR_PATTERN = 3'h2; // Tail 010 of writes
	localparam logic [DEV_W-1:0] ALL_DEV_ADDR = 5'h00;

	// ==========================================================
	// Chain and conversion limits
	localparam int MAX_DEVICES = 8;
	localparam int MAX_CONV = 12;
	localparam logic [3:0] CONV_12 = 4'hC;
	localparam logic [3:0] CONV_9 = 4'h9;
	localparam logic [3:0] CONV_6 = 4'h6;
	localparam logic [REGA_W-1:0] READ_SEL_REG = 6'h01; // Read-select register address
	localparam int SYNC_N = 8; // Number of synchronised pins

	// Source of the word loaded at frame start
	typedef enum logic [1:0] {
		BMRC_SRC_CONV,
		BMRC_SRC_REG,
		BMRC_SRC_RELAY
	} bmrc_src_type;

endpackage : bmrc_pkg

//--- src/bmrc_result_mem.sv
// Small store of conversion results with registered read data
`timescale 1ns/1ps
`default_nettype none
module bmrc_result_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 16,
	parameter int IDX_W = 4
) (
	input wire logic mclk_in,
	input wire logic wr_en_in,
	input wire logic [IDX_W-1:0] wr_idx_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic [IDX_W-1:0] rd_idx_in,
	output logic [WIDTH-1:0] rd_data_out
);

	// ==========================================================
	// Storage
	logic [WIDTH-1:0] mem [DEPTH]; // Result words

	// Depth must be reachable through the index
	if (DEPTH > (1 << IDX_W)) begin : g_bad_depth
		$error("result store depth exceeds index range");
	end

	// Write port
	always_ff @(posedge mclk_in) begin
		if (wr_en_in) begin
			mem[wr_idx_in] <= wr_data_in;
		end
	end

	// Registered read port
	always_ff @(posedge mclk_in) begin
		rd_data_out <= mem[rd_idx_in];
	end

endmodule : bmrc_result_mem
`default_nettype wire

//--- src/bmrc_serial_port.sv
// Serial port, frame builder, CRC check and chain relay of one stacked monitor
`timescale 1ns/1ps
`default_nettype none
// Function
// - conversion frame carries four-bit channel code
// - six-bit register address below device address
// - register frame returns selected register contents
// - conversion frame carries twelve-bit result
// - write CRC checked before execution
// - matching CRC executes and acknowledges
// - read CRC over top 22 bits
// - conversion frame field layout
// - register frame field layout
// - device address LSB first, rest MSB
// - chain of up to eight devices
// - all seven interface signals relayed
// - upward inputs serve host or chain
// - upper device tristates data and alert
// - one write frame reaches any device
// - 32-bit frames, counter reset on select
// - mode 1, sample fall, drive rise
// - CRC polynomial of degree eight
module bmrc_serial_port #(
	parameter int NUM_DEVICES = bmrc_pkg::MAX_DEVICES,
	parameter int RES_DEPTH = 16
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic sdi_in,
	input wire logic convert_start_in,
	input wire logic power_down_in,
	input wire logic above_data_in,
	input wire logic above_alert_in,
	input wire logic master_in,
	input wire logic chain_readback_in,
	input wire logic alert_in,
	input wire logic [bmrc_pkg::DEV_W-1:0] dev_addr_in,
	input wire logic res_wr_in,
	input wire logic [3:0] res_idx_in,
	input wire logic [bmrc_pkg::CHAN_W-1:0] res_chan_in,
	input wire logic [bmrc_pkg::RES_W-1:0] res_data_in,
	input wire logic conv_done_in,
	input wire logic [3:0] num_conv_in,
	input wire logic [bmrc_pkg::REGD_W-1:0] read_reg_data_in,
	output logic sdo_out,
	output logic sdo_oe_out,
	output logic alert_out,
	output logic alert_oe_out,
	output logic downward_data_out,
	output logic downward_alert_out,
	output logic upward_cs_n_out,
	output logic upward_clock_out,
	output logic upward_data_out,
	output logic upward_convert_start_out,
	output logic upward_power_down_out,
	output logic wr_strobe_out,
	output logic [bmrc_pkg::REGA_W-1:0] wr_reg_addr_out,
	output logic [bmrc_pkg::REGD_W-1:0] wr_data_out,
	output logic crc_error_out,
	output logic [bmrc_pkg::REGA_W-1:0] read_sel_addr_out
);
	import bmrc_pkg::*;

	// ==========================================================
	// Elaboration checks
	if (NUM_DEVICES < 1 || NUM_DEVICES > MAX_DEVICES) begin : g_bad_dev
		$error("chain length out of range");
	end
	if (RES_DEPTH < MAX_CONV || RES_DEPTH > 16) begin : g_bad_depth
		$error("result store cannot hold a full conversion set");
	end

	// ==========================================================
	// Helper functions

	// Remainder of the low len bits of d divided by the polynomial, MSB first
	function automatic logic [7:0] crc8(input logic [21:0] d, input int len);
		logic [7:0] c;
		logic fb;
		c = CRC_INIT;
		fb = 1'b0;
		for (int i = 21; i >= 0; i--) begin
			if (i < len) begin
				fb = c[7]; // Bit leaving the remainder
				c = {c[6:0], d[i]} ^ (fb ? CRC_POLY : 8'h00);
			end
		end
		return c;
	endfunction : crc8

	// Bit reversal of the device address field
	function automatic logic [DEV_W-1:0] rev5(input logic [DEV_W-1:0] a);
		logic [DEV_W-1:0] r;
		r = '0;
		for (int i = 0; i < DEV_W; i++) begin
			r[i] = a[DEV_W-1-i];
		end
		return r;
	endfunction : rev5

	// ==========================================================
	// Pin synchronisers
	logic [SYNC_N-1:0] pin_raw; // Pins from outside the clock domain
	logic [SYNC_N-1:0] sync1; // First stage, read by second stage only
	logic [SYNC_N-1:0] sync2; // Safe copies
	assign pin_raw = {master_in, above_alert_in, above_data_in, power_down_in,
		convert_start_in, sdi_in, sclk_in, cs_n_in};

	// Two flip-flops per pin
	for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
		always_ff @(posedge mclk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				sync1[g] <= 1'b1;
				sync2[g] <= 1'b1;
			end else begin
				sync1[g] <= pin_raw[g];
				sync2[g] <= sync1[g];
			end
		end
	end

	logic cs_n_s; // Synchronised select
	logic sclk_s; // Synchronised serial clock
	logic sdi_s; // Synchronised data in
	logic above_data_s; // Data coming down from the device above
	logic above_alert_s; // Alert coming down from the device above
	logic master_s; // Bottom-device strap
	assign cs_n_s = sync2[0];
	assign sclk_s = sync2[1];
	assign sdi_s = sync2[2];
	assign above_data_s = sync2[5];
	assign above_alert_s = sync2[6];
	assign master_s = sync2[7];

	// ==========================================================
	// Edge detection
	logic sclk_q; // Previous serial clock
	logic cs_n_q; // Previous select
	logic sclk_rise; // Clock rose during a frame
	logic sclk_fall; // Clock fell during a frame
	logic cs_fall; // Frame starts
	logic cs_rise; // Frame ends

	// Delayed copies for edge detection
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			sclk_q <= sclk_s;
			cs_n_q <= cs_n_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_q & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_q & ~cs_n_s;
	assign cs_fall = ~cs_n_s & cs_n_q;
	assign cs_rise = cs_n_s & ~cs_n_q;

	// ==========================================================
	// Receive side
	logic [CNT_W-1:0] bit_cnt; // Falling edges seen in this frame
	logic [FRAME_BITS-1:0] rx_sh; // Command from below
	logic [FRAME_BITS-1:0] above_sh; // Word from the device above

	// Bit counter, cleared at each frame start
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bit_cnt <= '0;
		end else if (cs_fall || cs_rise) begin
			bit_cnt <= '0;
		end else if (sclk_fall && bit_cnt <= FRAME_BITS_CNT) begin
			bit_cnt <= bit_cnt + 6'h01;
		end
	end

	// Shift in on falling edges, MSB first
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_sh <= '0;
			above_sh <= '0;
		end else if (sclk_fall) begin
			rx_sh <= {rx_sh[FRAME_BITS-2:0], sdi_s};
			above_sh <= {above_sh[FRAME_BITS-2:0], above_data_s};
		end
	end

	// ==========================================================
	// Write decode at frame end
	logic frame_ok; // Exactly 32 bits in the frame
	logic [DEV_W-1:0] rx_dev; // Received address in natural order
	logic [7:0] rx_crc_calc; // CRC of D31..D11
	logic wr_good; // CRC and tail pattern match
	logic wr_hit; // Write targets this device
	assign frame_ok = cs_rise && (bit_cnt == FRAME_BITS_CNT);
	assign rx_dev = rev5(rx_sh[ADDR_HI:ADDR_LO]);
	assign rx_crc_calc = crc8({1'b0, rx_sh[ADDR_HI:WCOV_LO]}, WCRC_LEN);
	assign wr_good = (rx_crc_calc == rx_sh[WCRC_HI:WCRC_LO]) && (rx_sh[2:0] == WR_PATTERN);
	assign wr_hit = wr_good && (rx_sh[ALL_POS] ? (rx_dev == ALL_DEV_ADDR) : (rx_dev == dev_addr_in));

	logic ack; // Acknowledge for the next frame
	logic reg_pending; // A register frame is due

	// Execute writes, update acknowledge
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_strobe_out <= 1'b0;
			wr_reg_addr_out <= '0;
			wr_data_out <= '0;
			crc_error_out <= 1'b0;
			ack <= 1'b0;
			read_sel_addr_out <= '0;
		end else begin
			wr_strobe_out <= frame_ok && wr_hit;
			crc_error_out <= frame_ok && !wr_good;
			if (frame_ok) begin
				ack <= wr_good;
				if (wr_hit) begin
					wr_reg_addr_out <= rx_sh[REGA_HI:REGA_LO];
					wr_data_out <= rx_sh[REGD_HI:REGD_LO];
					if (rx_sh[REGA_HI:REGA_LO] == READ_SEL_REG) begin
						read_sel_addr_out <= rx_sh[REGD_LO+REGA_W-1:REGD_LO];
					end
				end
			end
		end
	end

	// ==========================================================
	// Conversion result store
	logic [3:0] conv_left; // Conversion frames still to send
	logic [3:0] rd_ptr; // Next result to send
	logic [CHAN_W+RES_W-1:0] res_word; // Channel and result at rd_ptr

	bmrc_result_mem #(
		.DEPTH(RES_DEPTH),
		.WIDTH(CHAN_W + RES_W),
		.IDX_W(4)
	) u_mem (
		.mclk_in(mclk_in),
		.wr_en_in(res_wr_in),
		.wr_idx_in(res_idx_in),
		.wr_data_in({res_chan_in, res_data_in}),
		.rd_idx_in(rd_ptr),
		.rd_data_out(res_word)
	);

	// ==========================================================
	// Frame selection and building
	logic [FRAME_BITS-1:0] relay_word; // Word caught from above last frame
	logic relay_valid; // relay_word holds a full frame
	bmrc_src_type src; // Source for the next frame
	logic [FRAME_BITS-1:0] next_frame; // Word to load at frame start

	// Pick the source: own results first, then a pending register frame, then relay, then register
	always_comb begin
		if (conv_left != 4'h0) begin
			src = BMRC_SRC_CONV;
		end else if (!reg_pending && chain_readback_in && relay_valid) begin
			src = BMRC_SRC_RELAY;
		end else begin
			src = BMRC_SRC_REG;
		end
	end

	// Assemble the outgoing word with its CRC
	always_comb begin
		logic [FRAME_BITS-1:0] f;
		f = '0;
		case (src)
			BMRC_SRC_CONV: begin
				f[ADDR_HI:ADDR_LO] = rev5(dev_addr_in);
				f[CHAN_HI:CHAN_LO] = res_word[CHAN_W+RES_W-1:RES_W];
				f[RES_HI:RES_LO] = res_word[RES_W-1:0];
				f[ACK_POS] = ack;
				f[RCRC_HI:RCRC_LO] = crc8(f[ADDR_HI:ACK_POS], RCRC_LEN);
			end
			BMRC_SRC_REG: begin
				f[ADDR_HI:ADDR_LO] = rev5(dev_addr_in);
				f[REGA_HI:REGA_LO] = read_sel_addr_out;
				f[REGD_HI:REGD_LO] = read_reg_data_in;
				f[ACK_POS] = ack;
				f[RCRC_HI:RCRC_LO] = crc8(f[ADDR_HI:ACK_POS], RCRC_LEN);
			end
			BMRC_SRC_RELAY: begin
				f = relay_word;
			end
			default: begin
				f = '0;
			end
		endcase
		next_frame = f;
	end

	// Conversion pointer and pending flags
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			conv_left <= 4'h0;
			rd_ptr <= 4'h0;
			reg_pending <= 1'b0;
		end else begin
			if (conv_done_in) begin
				// New conversion set restarts the queue
				conv_left <= num_conv_in;
				rd_ptr <= 4'h0;
			end else if (cs_fall && src == BMRC_SRC_CONV) begin
				conv_left <= conv_left - 4'h1;
				rd_ptr <= rd_ptr + 4'h1;
			end
			// A completed write wins over consuming the flag
			if (frame_ok && wr_hit) begin
				reg_pending <= 1'b1;
			end else if (cs_fall && src == BMRC_SRC_REG) begin
				reg_pending <= 1'b0;
			end
		end
	end

	// Catch the word from above at each full frame
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			relay_word <= '0;
			relay_valid <= 1'b0;
		end else if (frame_ok) begin
			relay_word <= above_sh;
			relay_valid <= 1'b1;
		end else if (cs_rise) begin
			relay_valid <= 1'b0; // Short frame spoils it
		end
	end

	// ==========================================================
	// Transmit side
	logic [FRAME_BITS-1:0] tx_sh; // Outgoing shift register
	logic tx_bit; // Bit on the line

	// Load at frame start, shift on rising edges
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_sh <= '0;
			tx_bit <= 1'b0;
		end else if (cs_fall) begin
			tx_sh <= next_frame;
		end else if (sclk_rise) begin
			tx_bit <= tx_sh[FRAME_BITS-1];
			tx_sh <= {tx_sh[FRAME_BITS-2:0], 1'b0};
		end
	end

	// Route data and alert by chain position
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sdo_out <= 1'b0;
			sdo_oe_out <= 1'b0;
			alert_out <= 1'b0;
			alert_oe_out <= 1'b0;
			downward_data_out <= 1'b0;
			downward_alert_out <= 1'b0;
		end else begin
			sdo_out <= master_s & tx_bit;
			sdo_oe_out <= master_s;
			alert_out <= master_s & (alert_in | above_alert_s);
			alert_oe_out <= master_s;
			downward_data_out <= ~master_s & tx_bit;
			downward_alert_out <= ~master_s & (alert_in | above_alert_s);
		end
	end

	// Relay upward signals to the device above
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			upward_cs_n_out <= 1'b1;
			upward_clock_out <= 1'b0;
			upward_data_out <= 1'b0;
			upward_convert_start_out <= 1'b1;
			upward_power_down_out <= 1'b1;
		end else begin
			upward_cs_n_out <= cs_n_s;
			upward_clock_out <= sclk_s;
			upward_data_out <= sdi_s;
			upward_convert_start_out <= sync2[3];
			upward_power_down_out <= sync2[4];
		end
	end

endmodule : bmrc_serial_port
`default_nettype wire

//--- tb/bmrc_serial_port_asserts.sv
// Port-level checks of the read-back chain serial port
`timescale 1ns/1ps
`default_nettype none
module bmrc_serial_port_asserts (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic sdi_in,
	input wire logic convert_start_in,
	input wire logic power_down_in,
	input wire logic above_alert_in,
	input wire logic master_in,
	input wire logic alert_in,
	input wire logic sdo_oe_out,
	input wire logic alert_out,
	input wire logic alert_oe_out,
	input wire logic downward_data_out,
	input wire logic downward_alert_out,
	input wire logic upward_cs_n_out,
	input wire logic upward_clock_out,
	input wire logic upward_data_out,
	input wire logic upward_convert_start_out,
	input wire logic upward_power_down_out,
	input wire logic wr_strobe_out,
	input wire logic [bmrc_pkg::REGA_W-1:0] wr_reg_addr_out,
	input wire logic [bmrc_pkg::REGD_W-1:0] wr_data_out,
	input wire logic crc_error_out,
	input wire logic [bmrc_pkg::REGA_W-1:0] read_sel_addr_out
);
	import bmrc_pkg::*;
	// ==========================================
	// Cycles since reset, saturating; hides synchroniser warm-up
	logic [2:0] up_cnt;
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			up_cnt <= 3'h0;
		end else if (up_cnt != 3'h7) begin
			up_cnt <= up_cnt + 3'h1;
		end
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	// ==========================================
	// Relay, drive and frame checks
	a_cs_relay: assert property (up_cnt == 3'h7 |-> upward_cs_n_out == $past(cs_n_in, 3))
		else $error("select relay wrong");
	a_clock_relay: assert property (up_cnt == 3'h7 |-> upward_clock_out == $past(sclk_in, 3))
		else $error("clock relay wrong");
	a_data_relay: assert property (up_cnt == 3'h7 |-> upward_data_out == $past(sdi_in, 3))
		else $error("data relay wrong");
	a_start_relay: assert property (up_cnt == 3'h7 |-> upward_convert_start_out == $past(convert_start_in, 3))
		else $error("convert start relay wrong");
	a_pd_relay: assert property (up_cnt == 3'h7 |-> upward_power_down_out == $past(power_down_in, 3))
		else $error("power down relay wrong");
	a_oe_master: assert property (up_cnt == 3'h7 |-> sdo_oe_out == master_in && alert_oe_out == master_in)
		else $error("pin drive not tied to master");
	a_down_quiet: assert property (up_cnt == 3'h7 && sdo_oe_out |-> !downward_data_out)
		else $error("downward data active on master");
	a_alert_master: assert property ($rose(alert_in) && sdo_oe_out |-> ##[0:4] alert_out)
		else $error("alert not shown");
	a_alert_down: assert property ($rose(above_alert_in) && !sdo_oe_out && up_cnt == 3'h7 |-> ##[0:4] downward_alert_out)
		else $error("alert not passed down");
	a_strobe_pulse: assert property (wr_strobe_out |=> !wr_strobe_out)
		else $error("write strobe too long");
	a_strobe_alone: assert property (!(wr_strobe_out && crc_error_out))
		else $error("write executed with bad check");
	a_frame_gap: assert property (wr_strobe_out || crc_error_out |-> cs_n_in && $past(cs_n_in, 3))
		else $error("frame judged before select rose");
	a_read_select: assert property (wr_strobe_out && wr_reg_addr_out == READ_SEL_REG
		|-> ##[0:2] read_sel_addr_out == wr_data_out[5:0])
		else $error("read select not taken");
endmodule : bmrc_serial_port_asserts
bind bmrc_serial_port bmrc_serial_port_asserts u_chk (.*);
`default_nettype wire

//--- tb/bmrc_host_model.sv
// Host controller model: mode 1 master plus the device above
`timescale 1ns/1ps
`default_nettype none
module bmrc_host_model (
	input wire logic mclk_in,
	input wire logic miso_in,
	output var logic cs_n_out = 1'b1,
	output var logic sclk_out = 1'b0,
	output var logic mosi_out = 1'b0,
	output var logic above_out = 1'b0
);
	logic [31:0] up_word = 32'h0; // Word the device above sends down
	// ==========================================
	// One frame; half period of 4 mclk, clock idles low
	task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
		rx = 32'h0;
		@(posedge mclk_in);
		cs_n_out <= 1'b0;
		repeat (4) @(posedge mclk_in);
		for (int i = 0; i < nbits; i++) begin
			// Bit taken just before the next rise
			if (i > 0) begin
				rx = {rx[30:0], miso_in};
			end
			sclk_out <= 1'b1;
			mosi_out <= tx[31-i];
			above_out <= up_word[31-i];
			repeat (4) @(posedge mclk_in);
			sclk_out <= 1'b0;
			repeat (4) @(posedge mclk_in);
		end
		repeat (4) @(posedge mclk_in);
		rx = {rx[30:0], miso_in};
		cs_n_out <= 1'b1;
		// Released lines must not keep the last bit
		mosi_out <= ~mosi_out;
		above_out <= ~above_out;
		repeat (8) @(posedge mclk_in);
	endtask : frame
endmodule : bmrc_host_model
`default_nettype wire

//--- tb/battery_monitor_readback_chain_tb.sv
// Self-checking bench of the read-back chain serial port
`timescale 1ns/1ps
`default_nettype none
module battery_monitor_readback_chain_tb;
	import bmrc_pkg::*;
	// ==========================================
	// Stimulus and observed signals
	logic mclk_in = 1'b0, rstn_in = 1'b0, master_in = 1'b1, chain_readback_in = 1'b0;
	logic alert_in = 1'b0, above_alert_in = 1'b0, convert_start_in = 1'b1, power_down_in = 1'b1;
	logic res_wr_in = 1'b0, conv_done_in = 1'b0;
	logic [4:0] dev_addr_in = 5'h03;
	logic [3:0] res_idx_in = 4'h0, res_chan_in = 4'h0, num_conv_in = CONV_6;
	logic [11:0] res_data_in = 12'h000;
	logic [7:0] read_reg_data_in = 8'hA5;
	wire logic cs_n_in, sclk_in, sdi_in, above_data_in, miso;
	logic sdo_out, sdo_oe_out, alert_out, alert_oe_out, downward_data_out, downward_alert_out;
	logic upward_cs_n_out, upward_clock_out, upward_data_out, upward_convert_start_out, upward_power_down_out;
	logic wr_strobe_out, crc_error_out;
	logic [5:0] wr_reg_addr_out, read_sel_addr_out;
	logic [7:0] wr_data_out;
	int n_mismatch = 0, num_checks = 0, n_stb = 0, n_err = 0;
	localparam logic [31:0] IDLE = 32'hF800030A;
	// Host reads whichever line the device drives
	assign miso = master_in ? sdo_out : downward_data_out;
	bmrc_serial_port dut (.*);
	bmrc_host_model host (.mclk_in(mclk_in), .miso_in(miso), .cs_n_out(cs_n_in), .sclk_out(sclk_in),
		.mosi_out(sdi_in), .above_out(above_data_in));
	initial forever #4 mclk_in = ~mclk_in;
	// Count write and error pulses
	always @(posedge mclk_in) begin
		if (wr_strobe_out === 1'b1) n_stb++;
		if (crc_error_out === 1'b1) n_err++;
	end
	// ==========================================
	// Helpers
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic [7:0] crc8(input logic [31:0] w, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i > 31 - n; i--) c = {c[6:0], w[i]} ^ (c[7] ? CRC_POLY : 8'h00);
		return c;
	endfunction : crc8
	function automatic logic [4:0] rev5(input logic [4:0] a);
		return {a[0], a[1], a[2], a[3], a[4]};
	endfunction : rev5
	function automatic logic [31:0] wword(input logic [4:0] a, input logic [5:0] r, input logic [7:0] d,
		input logic al);
		logic [31:0] w;
		w = {rev5(a), r, d, al, 12'h000};
		w[10:3] = crc8(w, 21);
		w[2:0] = WR_PATTERN;
		return w;
	endfunction : wword
	function automatic logic [31:0] rframe(input logic [4:0] a, input logic [15:0] body, input logic ack);
		logic [31:0] w;
		w = {rev5(a), body, ack, 10'h000};
		w[9:2] = crc8(w, 22);
		return w;
	endfunction : rframe
	task automatic close_out;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	// ==========================================
	// Scenarios
	task automatic do_reset(input logic m);
		@(posedge mclk_in);
		rstn_in <= 1'b0;
		master_in <= m;
		chain_readback_in <= ~m;
		repeat (3) @(posedge mclk_in);
		chk("reset strobe", wr_strobe_out, 32'h0);
		chk("reset drive", sdo_oe_out, 32'h0);
		chk("reset select relay", upward_cs_n_out, 32'h1);
		chk("reset start relay", upward_convert_start_out, 32'h1);
		rstn_in <= 1'b1;
		repeat (8) @(posedge mclk_in);
	endtask : do_reset
	task automatic t_write;
		logic [31:0] rx;
		host.frame(wword(dev_addr_in, READ_SEL_REG, 8'h15, 1'b0), 32, rx);
		chk("first frame", rx, rframe(dev_addr_in, {6'h00, 8'hA5, 2'h0}, 1'b0));
		chk("read crc", rx[9:2], crc8(rx, 22));
		chk("strobes", n_stb, 32'h1);
		chk("write address", wr_reg_addr_out, READ_SEL_REG);
		chk("write data", wr_data_out, 32'h15);
		chk("read select", read_sel_addr_out, 32'h15);
		host.frame(wword(5'h04, 6'h02, 8'h33, 1'b0), 32, rx);
		chk("register frame", rx, rframe(dev_addr_in, {6'h15, 8'hA5, 2'h0}, 1'b1));
		chk("foreign write", n_stb, 32'h1);
		host.frame(wword(5'h00, 6'h02, 8'h44, 1'b1), 32, rx);
		chk("broadcast write", wr_data_out, 32'h44);
		alert_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		chk("alert", alert_out, 32'h1);
		alert_in <= 1'b0;
	endtask : t_write
	task automatic t_bad;
		logic [31:0] rx;
		logic [31:0] good;
		good = wword(dev_addr_in, READ_SEL_REG, 8'h2A, 1'b0);
		host.frame(good ^ 32'h8, 32, rx);
		chk("bad check flagged", n_err, 32'h1);
		host.frame(good ^ 32'h1, 32, rx);
		chk("bad tail flagged", n_err, 32'h2);
		chk("ack cleared", rx, rframe(dev_addr_in, {6'h15, 8'hA5, 2'h0}, 1'b0));
		host.frame(good, 31, rx);
		chk("short frame write", n_stb, 32'h2);
		chk("short frame select", read_sel_addr_out, 32'h15);
		host.frame(IDLE, 32, rx);
		chk("ack kept", rx, rframe(dev_addr_in, {6'h15, 8'hA5, 2'h0}, 1'b0));
	endtask : t_bad
	task automatic t_conv;
		logic [31:0] rx;
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk_in);
			res_wr_in <= 1'b1;
			res_idx_in <= 4'(i);
			res_chan_in <= 4'(i + 1);
			res_data_in <= 12'h123 * 12'(i + 1);
			@(posedge mclk_in);
			res_wr_in <= 1'b0;
		end
		@(posedge mclk_in);
		conv_done_in <= 1'b1;
		@(posedge mclk_in);
		conv_done_in <= 1'b0;
		repeat (4) @(posedge mclk_in);
		for (int i = 0; i < 6; i++) begin
			host.frame(IDLE, 32, rx);
			chk("conversion frame", rx, rframe(dev_addr_in, {4'(i + 1), 12'h123 * 12'(i + 1)}, 1'b1));
		end
		host.frame(IDLE, 32, rx);
		chk("after last result", rx, rframe(dev_addr_in, {6'h15, 8'hA5, 2'h0}, 1'b1));
	endtask : t_conv
	task automatic t_relay;
		logic [31:0] rx;
		do_reset(1'b0);
		host.up_word = 32'hC3A55A3C;
		host.frame(IDLE, 32, rx);
		chk("upper drive off", sdo_oe_out, 32'h0);
		host.frame(IDLE, 32, rx);
		chk("relayed word", rx, 32'hC3A55A3C);
		chain_readback_in <= 1'b0;
		host.frame(IDLE, 32, rx);
		chk("single upper read", rx, rframe(dev_addr_in, {6'h00, 8'hA5, 2'h0}, 1'b1));
		above_alert_in <= 1'b1;
		convert_start_in <= 1'b0;
		power_down_in <= 1'b0;
		repeat (6) @(posedge mclk_in);
		chk("alert down", downward_alert_out, 32'h1);
		chk("start up", upward_convert_start_out, 32'h0);
		chk("power down up", upward_power_down_out, 32'h0);
	endtask : t_relay
	initial begin
		do_reset(1'b1);
		t_write;
		t_bad;
		t_conv;
		t_relay;
		close_out;
	end
endmodule : battery_monitor_readback_chain_tb
`default_nettype wire
